// file: pwt_regs.svh
// register map, field positions and constants of the protected watchdog timer
//------------------------------------------------------------------------------
// Operation
// - in protect mode the counter is clocked by the dedicated 125 kHz oscillator only.
// - in protect mode one period is the selected reload count plus one over the oscillator rate.
// - bit 7 of the protect control register set to 1 enables protect mode, 0 leaves it off.
// - a protect-at-reset option bit of 0 makes the protect enable bit read 1 after reset.
// - reload option bits 1-0 pick the start value 03FFh, 0FFFh, 1FFFh or 3FFFh.
// - duty option bits 3-2 pick a refresh window of 25, 50, 75 or 100 percent.
// - a refresh happens only when 00h and then FFh are written to the refresh register.
// - a refresh reloads the counter with the start value picked by the reload option.
// - start option bit 0 at 0 starts counting after reset, at 1 keeps the timer stopped.
// - any write to the start register starts a stopped counter.
// - with protect mode off the count view returns counter bits 10 down to 5.
// - with protect mode on the six-bit count view slice follows the reload option.
// - an underflow sets the detect flag in bit 3 of the detect control register.
//------------------------------------------------------------------------------
`ifndef PWT_REGS_SVH
`define PWT_REGS_SVH

// register indices; byte address is four times the index
`define PWT_IDX_DETECT_CTRL 20'h0002C
`define PWT_IDX_PROTECT_CTRL 20'h0037C
`define PWT_IDX_REFRESH 20'h0037D
`define PWT_IDX_START 20'h0037E
`define PWT_IDX_COUNT_VIEW 20'h0037F
`define PWT_IDX_OPT_START 20'h0FFFF
`define PWT_IDX_OPT_RELOAD 20'hFFFDB
`define PWT_IDX_IRQ_STATUS 20'h00380
`define PWT_IDX_IRQ_MASK 20'h00381

// field positions
`define PWT_BIT_DETECT_FLAG 3
`define PWT_BIT_PROTECT_EN 7
`define PWT_BIT_AUTO_START 0
`define PWT_BIT_PROTECT_AT_RESET 7
`define PWT_LSB_RELOAD_SEL 0
`define PWT_LSB_DUTY_SEL 2
`define PWT_BIT_IRQ_UNDERFLOW 0

// reload start values
`define PWT_RELOAD_0 15'h03FF
`define PWT_RELOAD_1 15'h0FFF
`define PWT_RELOAD_2 15'h1FFF
`define PWT_RELOAD_3 15'h3FFF

// refresh key bytes
`define PWT_KEY_FIRST 8'h00
`define PWT_KEY_SECOND 8'hFF

// reset values
`define PWT_RST_BYTE 8'h00
`define PWT_RST_COUNT 15'h0000

// dedicated oscillator rate and system clock rate in kHz
`define PWT_OSC_KHZ 125
`define PWT_CLK_KHZ 20000

`endif

// file: pwt_pkg.sv
// types shared by the protected watchdog timer
package pwt_pkg;

    // option bytes as captured after reset
    typedef struct packed {
        logic [7:0] start_sel;
        logic [7:0] reload_duty;
    } pwt_opt_t;

    // refresh key sequence
    typedef enum logic [0:0] {
        PWT_KEY_IDLE,
        PWT_KEY_ARMED
    } pwt_key_t;

endpackage : pwt_pkg

// file: pwt_top.sv
// protected watchdog timer with apb register access
`timescale 1ns/10ps
`include "pwt_regs.svh"

module pwt_top
    import pwt_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [21:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // dedicated low oscillator and option bytes
    input wire logic WDT_OSC_I,
    input wire logic [7:0] OPT_START_SELECT_I,
    input wire logic [7:0] OPT_RELOAD_DUTY_I,
    // status
    output logic UNDERFLOW_O,
    output logic RUNNING_O,
    output logic IRQ_O
);

    //--------------------------------------------------------------------------
    // functions
    //--------------------------------------------------------------------------
    function automatic logic [14:0] reload_value(input logic [1:0] sel);
        logic [14:0] v;
        v = `PWT_RELOAD_3;
        unique case (sel)
            2'b00: v = `PWT_RELOAD_0;
            2'b01: v = `PWT_RELOAD_1;
            2'b10: v = `PWT_RELOAD_2;
            2'b11: v = `PWT_RELOAD_3;
        endcase
        return v;
    endfunction

    function automatic logic is_reg(input logic [21:0] addr, input logic [19:0] idx);
        return addr[21:2] == idx && addr[1:0] == 2'b00;
    endfunction

    //--------------------------------------------------------------------------
    // input synchronisers
    //--------------------------------------------------------------------------
    logic [2:0] osc_sync;
    logic [7:0] opt_start_meta;
    logic [7:0] opt_start_sync;
    logic [7:0] opt_reload_meta;
    logic [7:0] opt_reload_sync;

    // osc_sync[0] feeds only osc_sync[1]; the edge is seen on [2:1]
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            osc_sync <= 3'h0;
        end else begin
            osc_sync <= {osc_sync[1:0], WDT_OSC_I};
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            opt_start_meta <= `PWT_RST_BYTE;
            opt_start_sync <= `PWT_RST_BYTE;
            opt_reload_meta <= `PWT_RST_BYTE;
            opt_reload_sync <= `PWT_RST_BYTE;
        end else begin
            opt_start_meta <= OPT_START_SELECT_I;
            opt_start_sync <= opt_start_meta;
            opt_reload_meta <= OPT_RELOAD_DUTY_I;
            opt_reload_sync <= opt_reload_meta;
        end
    end

    //--------------------------------------------------------------------------
    // option capture after reset release
    //--------------------------------------------------------------------------
    // options are latched once, after the synchronisers have filled
    logic [1:0] boot_cnt;
    logic opt_load;
    pwt_opt_t opt;

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            boot_cnt <= 2'h0;
        end else if (boot_cnt != 2'h3) begin
            boot_cnt <= boot_cnt + 2'h1;
        end
    end

    assign opt_load = boot_cnt == 2'h2;

    // a stray zero in bits 7-4 of the reload byte is kept as given
    // upper option bits as supplied
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            opt <= '0;
        end else if (opt_load) begin
            opt <= {opt_start_sync, opt_reload_sync};
        end
    end

    logic [1:0] reload_sel;
    logic [1:0] duty_sel;
    logic [14:0] reload;
    assign reload_sel = opt.reload_duty[`PWT_LSB_RELOAD_SEL +: 2];
    assign duty_sel = opt.reload_duty[`PWT_LSB_DUTY_SEL +: 2];
    assign reload = reload_value(reload_sel);

    //--------------------------------------------------------------------------
    // apb slave
    //--------------------------------------------------------------------------
    // no wait state: decode in setup, answer in the first access cycle, so outputs stay flops
    logic setup;
    logic done;
    logic wr_done;
    logic rd_done;
    logic mapped;
    logic [31:0] next_rdata;
    logic [7:0] wbyte;

    assign setup = PSEL_I && !PENABLE_I;
    assign done = PSEL_I && PENABLE_I && PREADY_O;
    assign wr_done = done && PWRITE_I && !PSLVERR_O;
    assign rd_done = done && !PWRITE_I && !PSLVERR_O;
    assign wbyte = PWDATA_I[7:0];

    logic protect_en;
    logic detect_flag;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [14:0] counter;
    logic [5:0] view;

    assign mapped = is_reg(PADDR_I, `PWT_IDX_DETECT_CTRL)
        || is_reg(PADDR_I, `PWT_IDX_PROTECT_CTRL)
        || is_reg(PADDR_I, `PWT_IDX_REFRESH)
        || is_reg(PADDR_I, `PWT_IDX_START)
        || is_reg(PADDR_I, `PWT_IDX_COUNT_VIEW)
        || is_reg(PADDR_I, `PWT_IDX_OPT_START)
        || is_reg(PADDR_I, `PWT_IDX_OPT_RELOAD)
        || is_reg(PADDR_I, `PWT_IDX_IRQ_STATUS)
        || is_reg(PADDR_I, `PWT_IDX_IRQ_MASK);

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (is_reg(PADDR_I, `PWT_IDX_DETECT_CTRL)) begin
            next_rdata[`PWT_BIT_DETECT_FLAG] = detect_flag;
        end else if (is_reg(PADDR_I, `PWT_IDX_PROTECT_CTRL)) begin
            next_rdata[`PWT_BIT_PROTECT_EN] = protect_en;
        end else if (is_reg(PADDR_I, `PWT_IDX_COUNT_VIEW)) begin
            next_rdata[5:0] = view;
        end else if (is_reg(PADDR_I, `PWT_IDX_OPT_START)) begin
            next_rdata[7:0] = opt.start_sel;
        end else if (is_reg(PADDR_I, `PWT_IDX_OPT_RELOAD)) begin
            next_rdata[7:0] = opt.reload_duty;
        end else if (is_reg(PADDR_I, `PWT_IDX_IRQ_STATUS)) begin
            next_rdata[7:0] = irq_status;
        end else if (is_reg(PADDR_I, `PWT_IDX_IRQ_MASK)) begin
            next_rdata[7:0] = irq_mask;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
        end else if (setup) begin
            PREADY_O <= 1'b1;
            PSLVERR_O <= !mapped;
            PRDATA_O <= PWRITE_I ? 32'h0000_0000 : next_rdata;
        end else begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end
    end

    //--------------------------------------------------------------------------
    // protect mode control
    //--------------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            protect_en <= 1'b0;
        end else if (opt_load && !opt_start_sync[`PWT_BIT_PROTECT_AT_RESET]) begin
            protect_en <= 1'b1;
        end else if (wr_done && is_reg(PADDR_I, `PWT_IDX_PROTECT_CTRL)) begin
            protect_en <= wbyte[`PWT_BIT_PROTECT_EN];
        end
    end

    //--------------------------------------------------------------------------
    // count source
    //--------------------------------------------------------------------------
    // the slow oscillator is sampled, so it must stay well under half CLK_I
    logic tick;
    assign tick = protect_en ? (osc_sync[1] && !osc_sync[2]) : 1'b1;

    //--------------------------------------------------------------------------
    // refresh key sequence and window
    //--------------------------------------------------------------------------
    pwt_key_t key_state;
    logic refresh_wr;
    logic refresh;
    logic in_window;
    logic [14:0] window_limit;

    assign refresh_wr = wr_done && is_reg(PADDR_I, `PWT_IDX_REFRESH);

    // limit = quarter period times (duty + 1); counter below it may refresh
    assign window_limit = 15'((({1'b0, reload} + 16'h0001) >> 2) * ({14'h0000, duty_sel} + 16'h0001));
    assign in_window = (duty_sel == 2'b11) || (counter < window_limit);

    // any other byte breaks the sequence and must start over
    // two-write key
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            key_state <= PWT_KEY_IDLE;
        end else if (refresh_wr) begin
            key_state <= (wbyte == `PWT_KEY_FIRST) ? PWT_KEY_ARMED : PWT_KEY_IDLE;
        end
    end

    assign refresh = refresh_wr && key_state == PWT_KEY_ARMED
        && wbyte == `PWT_KEY_SECOND && in_window;

    //--------------------------------------------------------------------------
    // counter
    //--------------------------------------------------------------------------
    logic running;
    logic underflow;
    assign underflow = running && tick && counter == `PWT_RST_COUNT && !refresh;

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            running <= 1'b0;
        end else if (opt_load && !opt_start_sync[`PWT_BIT_AUTO_START]) begin
            running <= 1'b1;
        end else if (wr_done && is_reg(PADDR_I, `PWT_IDX_START)) begin
            running <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            counter <= `PWT_RST_COUNT;
        end else if (opt_load) begin
            counter <= reload_value(opt_reload_sync[`PWT_LSB_RELOAD_SEL +: 2]);
        end else if (refresh) begin
            counter <= reload;
        end else if (running && tick) begin
            // one step per source tick, period is reload plus one over source rate
            // count down and wrap on underflow
            counter <= (counter == `PWT_RST_COUNT) ? reload : counter - 15'h0001;
        end
    end

    //--------------------------------------------------------------------------
    // count view
    //--------------------------------------------------------------------------
    always_comb begin
        view = counter[10:5];
        if (protect_en) begin
            unique case (reload_sel)
                2'b00: view = counter[5:0];
                2'b01: view = counter[8:3];
                2'b10: view = counter[9:4];
                2'b11: view = counter[10:5];
            endcase
        end
    end

    //--------------------------------------------------------------------------
    // detect flag and interrupt
    //--------------------------------------------------------------------------
    // software clears the flag by writing 0; a same-cycle underflow wins
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            detect_flag <= 1'b0;
        end else if (underflow) begin
            detect_flag <= 1'b1;
        end else if (wr_done && is_reg(PADDR_I, `PWT_IDX_DETECT_CTRL)
                && !wbyte[`PWT_BIT_DETECT_FLAG]) begin
            detect_flag <= 1'b0;
        end
    end

    // read clears only the bits returned, so a new event is never lost
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            irq_status <= `PWT_RST_BYTE;
        end else begin
            irq_status <= (rd_done && is_reg(PADDR_I, `PWT_IDX_IRQ_STATUS)
                ? irq_status & ~PRDATA_O[7:0] : irq_status)
                | {7'h00, underflow};
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            irq_mask <= `PWT_RST_BYTE;
        end else if (wr_done && is_reg(PADDR_I, `PWT_IDX_IRQ_MASK)) begin
            irq_mask <= wbyte;
        end
    end

    //--------------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            UNDERFLOW_O <= 1'b0;
            RUNNING_O <= 1'b0;
            IRQ_O <= 1'b0;
        end else begin
            UNDERFLOW_O <= underflow;
            RUNNING_O <= running;
            IRQ_O <= |(irq_status & irq_mask);
        end
    end

endmodule // pwt_top

// file: pwt_top_properties.sv
// port checker of the protected watchdog timer, bound into pwt_top
`timescale 1ns/10ps
`include "pwt_regs.svh"

module pwt_chk (
    // clock and reset
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [21:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    // status
    input wire logic UNDERFLOW_O,
    input wire logic RUNNING_O,
    input wire logic IRQ_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    logic start_wr;
    assign start_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I
        && PADDR_I == {`PWT_IDX_START, 2'h0};

    // ----------------------------------------
    // properties
    // ----------------------------------------
    chk_ready_after_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("ready missing after setup");
    chk_ready_one_cycle: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    chk_err_with_ready: assert property (PSLVERR_O |-> PREADY_O && (PWRITE_I || PRDATA_O == 32'h0))
        else $error("error without ready or with data");
    chk_upper_bits_zero: assert property (PREADY_O |-> PRDATA_O[31:8] == 24'h0)
        else $error("read data upper bits set");
    chk_mapped_no_err: assert property (PREADY_O && PADDR_I == {`PWT_IDX_START, 2'h0} |-> !PSLVERR_O)
        else $error("error on mapped address");
    // running is set at the access edge and reaches the flopped output one edge later
    chk_start_runs: assert property (start_wr |-> ##2 RUNNING_O)
        else $error("start write did not run counter");
    chk_running_holds: assert property (RUNNING_O |=> RUNNING_O)
        else $error("running counter stopped");
    chk_stopped_quiet: assert property (!RUNNING_O ##1 !RUNNING_O |-> !UNDERFLOW_O)
        else $error("underflow while stopped");
    // reload is at least 03FFh ticks, so pulses are far apart
    chk_uf_pulse: assert property (UNDERFLOW_O |=> !UNDERFLOW_O [*8])
        else $error("underflow pulse too long");
    chk_uf_while_run: assert property (UNDERFLOW_O |-> $past(RUNNING_O))
        else $error("underflow without running counter");

    cover property (start_wr);
    cover property (UNDERFLOW_O);
    cover property (PSLVERR_O);
    cover property (IRQ_O);
endmodule // pwt_chk

bind pwt_top pwt_chk i_chk (
    .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .UNDERFLOW_O(UNDERFLOW_O), .RUNNING_O(RUNNING_O), .IRQ_O(IRQ_O)
);

// file: protected_watchdog_timer_tb.sv
// self-checking bench of the protected watchdog timer
`timescale 1ns/10ps
`include "pwt_regs.svh"

`define PWT_CHK(g, e) \
    begin \
        checks_done++; \
        if ((g) !== (e)) begin \
            num_errors++; \
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); \
        end \
    end

module protected_watchdog_timer_tb
    import pwt_pkg::*;
;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic psel = 1'h0;
    logic pen = 1'h0;
    logic pwr = 1'h0;
    logic [21:0] paddr = 22'h0;
    logic [31:0] pwdata = 32'h0;
    logic osc = 1'h0;
    pwt_opt_t opt = 16'hF0F0;
    logic [31:0] prdata;
    logic pready;
    logic perr;
    logic uf;
    logic run;
    logic irq;
    logic [31:0] rd;
    logic er;
    logic [1:0] s;
    logic [1:0] d;
    logic [14:0] r;
    logic [14:0] v;
    int num_errors = 0;
    int checks_done = 0;
    int seed = 88;
    int cnt;
    int n;

    initial forever #25 clk = ~clk;

    pwt_top i_dut (
        .CLK_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(perr), .WDT_OSC_I(osc), .OPT_START_SELECT_I(opt.start_sel),
        .OPT_RELOAD_DUTY_I(opt.reload_duty), .UNDERFLOW_O(uf), .RUNNING_O(run), .IRQ_O(irq)
    );

    // ----------------------------------------
    // tasks and functions
    // ----------------------------------------
    // no assumed wait count: only the watchdog ends a hung transfer
    task automatic apb(input logic w, input logic [19:0] i, input logic [7:0] dt);
        @(posedge clk);
        psel <= 1'h1;
        pen <= 1'h0;
        pwr <= w;
        paddr <= {i, 2'h0};
        pwdata <= {24'h0, dt};
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = perr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask

    task automatic rdr(input logic [19:0] i);
        apb(1'h0, i, 8'h0);
    endtask

    task automatic wr(input logic [19:0] i, input logic [7:0] dt);
        apb(1'h1, i, dt);
    endtask

    task automatic wait_uf(output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (uf !== 1'h1 && c < 20000);
        if (c >= 20000) begin
            num_errors++;
            summarize();
        end
    endtask

    // options must stay put until the boot sampling is over
    task automatic reset_dut(input pwt_opt_t o);
        @(posedge clk);
        rst_n <= 1'h0;
        opt <= o;
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        repeat (6) @(posedge clk);
    endtask

    // slow pulses so the two-flop sync never misses an edge
    task automatic tick(input int t);
        repeat (t) begin
            @(posedge clk);
            osc <= 1'h1;
            repeat (4) @(posedge clk);
            osc <= 1'h0;
            repeat (3) @(posedge clk);
        end
        repeat (6) @(posedge clk);
    endtask

    function automatic logic [14:0] rel(input logic [1:0] q);
        rel = q == 2'h0 ? `PWT_RELOAD_0 : q == 2'h1 ? `PWT_RELOAD_1 :
            q == 2'h2 ? `PWT_RELOAD_2 : `PWT_RELOAD_3;
    endfunction

    function automatic logic [5:0] view(input logic [14:0] c, input logic [1:0] q);
        case (q)
            2'h0: view = c[5:0];
            2'h1: view = c[8:3];
            2'h2: view = c[9:4];
            default: view = c[10:5];
        endcase
    endfunction

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        #4500000;
        num_errors++;
        summarize();
    end

    initial begin
        for (int k = 0; k < 8; k++) begin
            s = k[1:0];
            r = rel(s);
            d = k[2] ? 2'($random(seed)) : ~s;
            reset_dut({k[2], 6'h0, k[0], 4'hF, d, s}); // upper reload bits ones
            `PWT_CHK(run, !k[0])
            rdr(`PWT_IDX_PROTECT_CTRL);
            `PWT_CHK(rd[7], !k[2])
            rdr(`PWT_IDX_OPT_RELOAD);
            `PWT_CHK(rd[7:0], {4'hF, d, s})
            rdr(`PWT_IDX_DETECT_CTRL);
            `PWT_CHK(rd[3], 1'h0)
            if (k[0]) begin
                wr(`PWT_IDX_START, 8'($random(seed)));
                // running flops at the access edge, the output one edge later
                repeat (2) @(posedge clk);
                `PWT_CHK(run, 1'h1)
            end
            if (!k[2]) begin
                n = 1 + ($random(seed) & 31);
                tick(n);
                v = r - 15'(n);
                rdr(`PWT_IDX_COUNT_VIEW);
                `PWT_CHK(rd[5:0], view(v, s))
                wr(`PWT_IDX_REFRESH, 8'hFF);
                wr(`PWT_IDX_REFRESH, 8'h00);
                wr(`PWT_IDX_REFRESH, 8'h5A);
                wr(`PWT_IDX_REFRESH, 8'hFF);
                rdr(`PWT_IDX_COUNT_VIEW);
                `PWT_CHK(rd[5:0], view(v, s))
                wr(`PWT_IDX_REFRESH, 8'h00);
                wr(`PWT_IDX_REFRESH, 8'hFF);
                rdr(`PWT_IDX_COUNT_VIEW);
                `PWT_CHK(rd[5:0], view(s == 2'h0 ? r : v, s))
            end else begin
                wait_uf(cnt);
                wait_uf(cnt);
                `PWT_CHK(cnt, int'(r) + 1)
                rdr(`PWT_IDX_COUNT_VIEW);
                `PWT_CHK(rd[5:0], r[10:5])
                rdr(`PWT_IDX_DETECT_CTRL);
                `PWT_CHK(rd[3], 1'h1)
                wr(`PWT_IDX_DETECT_CTRL, 8'h00);
                rdr(`PWT_IDX_DETECT_CTRL);
                `PWT_CHK({rd[3], irq}, 2'h0)
                wr(`PWT_IDX_IRQ_MASK, 8'h01);
                repeat (2) @(posedge clk);
                `PWT_CHK(irq, 1'h1)
                rdr(`PWT_IDX_IRQ_STATUS);
                `PWT_CHK(rd[0], 1'h1)
                repeat (2) @(posedge clk);
                `PWT_CHK(irq, 1'h0)
                wr(`PWT_IDX_PROTECT_CTRL, 8'h80);
                rdr(`PWT_IDX_PROTECT_CTRL);
                `PWT_CHK(rd[7], 1'h1)
            end
        end
        wr(`PWT_IDX_OPT_START, 8'h5A);
        rdr(`PWT_IDX_OPT_START);
        `PWT_CHK(rd[7:0], opt.start_sel)
        rdr(20'h00123);
        `PWT_CHK({er, rd}, {1'h1, 32'h0})
        summarize();
    end
endmodule // protected_watchdog_timer_tb
